// ===== rtl/tmc_pkg.sv
/*
 * Package of the 16-bit timer/counter: register map, field positions,
 * reset values, counts and the operating mode type.
 * Assumes a 32-bit AXI4-Lite register bus with byte addresses of ADDR_W bits.
 */
package tmc_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_LO = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_COUNT_HI = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_FLAGS = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLES = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_PIN_CTRL = 8'h14;
   localparam logic [ADDR_W-1:0] ADDR_PIN_READ = 8'h18;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int CTL_RUN_BIT = 0;
   localparam int CTL_CS_BIT = 1;
   localparam int CTL_SYNC_N_BIT = 2;
   localparam int CTL_OSCEN_BIT = 3;
   localparam int CTL_PS_LSB = 4;
   localparam int CTL_STAT_BIT = 6;
   localparam int OVF_BIT = 0;
   localparam int PIN_DRV_LSB = 2;

   // ----------------------------------------
   // Values and counts
   // ----------------------------------------
   localparam logic [5:0] CTL_RESET = 6'h00;
   localparam logic [15:0] COUNT_ZERO = 16'h0000;
   localparam logic [15:0] COUNT_MAX = 16'hFFFF;
   localparam logic [1:0] SYSCLK_SEL_TIMER_OSC = 2'b01;
   localparam int INSTR_DIV_DEF = 4;
   localparam int PRE_BITS_DEF = 3;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {
      MODE_TIMER = 2'b00,
      MODE_SYNC = 2'b01,
      MODE_ASYNC = 2'b10
   } tmc_mode_t;

endpackage

// ===== rtl/tmc_pre_if.sv
/*
 * Carrier between the timer core and its prescaler.
 * Assumes both ends sit on the same aclk.
 */
`timescale 1ns/1ps
interface tmc_pre_if;
   logic tick_in;
   logic clear;
   logic [1:0] ratio_sel;
   logic tick_out;
   modport ctrl (output tick_in, output clear, output ratio_sel, input tick_out);
   modport pre (input tick_in, input clear, input ratio_sel, output tick_out);
endinterface

// ===== rtl/tmc_edge_sync.sv
/*
 * Rising edge detection on the external count pin: one path through a
 * two-stage synchroniser, one raw path for the unsynchronised mode.
 * Assumes the pin is slow against aclk.
 */
`timescale 1ns/1ps
module tmc_edge_sync (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin_i,
   output logic rise_sync,
   output logic rise_raw
);
   logic meta_reg;
   logic sync_reg;
   logic sync_prev_reg;
   logic raw_prev_reg;

   // Stage one feeds only stage two
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         meta_reg <= 1'b0;
         sync_reg <= 1'b0;
         sync_prev_reg <= 1'b0;
      end else begin
         meta_reg <= pin_i;
         sync_reg <= meta_reg;
         sync_prev_reg <= sync_reg;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         raw_prev_reg <= 1'b0;
      end else begin
         raw_prev_reg <= pin_i;
      end
   end

   assign rise_sync = sync_reg & ~sync_prev_reg;
   assign rise_raw = pin_i & ~raw_prev_reg;

endmodule // tmc_edge_sync

// ===== rtl/tmc_prescaler.sv
/*
 * Prescaler: passes one tick out of 1, 2, 4 or 8 ticks in.
 * Assumes tick_in is a one-cycle pulse and clear may come at any time.
 */
`timescale 1ns/1ps
module tmc_prescaler #(
   parameter int PRE_BITS = tmc_pkg::PRE_BITS_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   tmc_pre_if.pre bus
);
   import tmc_pkg::*;

   logic [PRE_BITS-1:0] cnt_reg;
   logic [PRE_BITS-1:0] mask;
   logic tick_out_reg;

   if (PRE_BITS < 3) begin : g_bad_width
      $error("PRE_BITS must hold a 1:8 ratio");
   end

   assign mask = PRE_BITS'((1 << bus.ratio_sel) - 1);
   assign bus.tick_out = tick_out_reg;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_reg <= '0;
         tick_out_reg <= 1'b0;
      end else if (bus.clear) begin
         cnt_reg <= '0;
         tick_out_reg <= 1'b0;
      end else if (bus.tick_in) begin
         // Full period done: emit and restart
         tick_out_reg <= ((cnt_reg & mask) == mask);
         cnt_reg <= ((cnt_reg & mask) == mask) ? '0 : cnt_reg + 1'b1;
      end else begin
         tick_out_reg <= 1'b0;
      end
   end

   presc_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      bus.clear |=> !bus.tick_out && cnt_reg == '0) else $error("prescaler not cleared");

endmodule // tmc_prescaler

// ===== rtl/tmc_timer_top.sv
/*
 * 16-bit timer/counter with prescaler, overflow flag, compare reset input
 * and oscillator pin control, reached over an AXI4-Lite slave.
 * Assumes one clock aclk at 40 MHz and inputs synchronous to it, except the
 * external count pin which is synchronised or edge detected here.
 */
`timescale 1ns/1ps
module tmc_timer_top #(
   parameter int INSTR_DIV = tmc_pkg::INSTR_DIV_DEF,
   parameter int PRE_BITS = tmc_pkg::PRE_BITS_DEF
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [tmc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [tmc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic compare_unit_trigger,
   input wire logic [1:0] system_clock_select,
   input wire logic timer_osc_fail,
   input wire logic osc_amp_output_pin_i,
   output logic osc_amp_output_pin_o,
   output logic osc_amp_output_pin_oe,
   input wire logic osc_input_pin_i,
   output logic osc_input_pin_o,
   output logic osc_input_pin_oe,
   output logic timer_osc_inverter_en,
   output logic overflow_irq,
   output logic [15:0] count_value
);
   import tmc_pkg::*;

   if (INSTR_DIV < 2 || INSTR_DIV > 256) begin : g_bad_div
      $error("INSTR_DIV out of range 2..256");
   end

   // ----------------------------------------
   // AXI4-Lite slave
   // ----------------------------------------
   logic aw_held_reg;
   logic w_held_reg;
   logic [ADDR_W-1:0] waddr_reg;
   logic [7:0] wbyte_reg;
   logic wlane_reg;
   logic awready_reg;
   logic wready_reg;
   logic bvalid_reg;
   logic [1:0] bresp_reg;
   logic arready_reg;
   logic rvalid_reg;
   logic [1:0] rresp_reg;
   logic [31:0] rdata_reg;
   logic [ADDR_W-1:0] raddr_reg;
   logic aw_hs;
   logic w_hs;
   logic ar_hs;
   logic commit;
   logic waddr_ok;

   assign aw_hs = s_axi_awvalid & awready_reg;
   assign w_hs = s_axi_wvalid & wready_reg;
   assign ar_hs = s_axi_arvalid & arready_reg;
   assign commit = aw_held_reg & w_held_reg & ~bvalid_reg;
   assign waddr_ok = (waddr_reg == ADDR_COUNT_LO) || (waddr_reg == ADDR_COUNT_HI) ||
                     (waddr_reg == ADDR_IRQ_FLAGS) || (waddr_reg == ADDR_IRQ_ENABLES) ||
                     (waddr_reg == ADDR_CONTROL) || (waddr_reg == ADDR_PIN_CTRL);

   // Address and data are taken in either order, then committed together
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_reg <= 1'b0;
         waddr_reg <= '0;
         awready_reg <= 1'b0;
      end else begin
         if (aw_hs) begin
            aw_held_reg <= 1'b1;
            waddr_reg <= s_axi_awaddr;
         end else if (commit) begin
            aw_held_reg <= 1'b0;
         end
         awready_reg <= ~(aw_hs | (aw_held_reg & ~commit));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         w_held_reg <= 1'b0;
         wbyte_reg <= 8'h00;
         wlane_reg <= 1'b0;
         wready_reg <= 1'b0;
      end else begin
         if (w_hs) begin
            w_held_reg <= 1'b1;
            wbyte_reg <= s_axi_wdata[7:0];
            wlane_reg <= s_axi_wstrb[0];
         end else if (commit) begin
            w_held_reg <= 1'b0;
         end
         wready_reg <= ~(w_hs | (w_held_reg & ~commit));
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_reg <= 1'b0;
         bresp_reg <= RESP_OKAY;
      end else if (commit) begin
         bvalid_reg <= 1'b1;
         bresp_reg <= waddr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
         bvalid_reg <= 1'b0;
      end
   end

   // Register write strobes; only byte lane 0 carries data
   logic wr_en;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_count;
   logic wr_flags;
   logic wr_enables;
   logic wr_ctl;
   logic wr_pins;

   assign wr_en = commit & wlane_reg;
   assign wr_cnt_lo = wr_en & (waddr_reg == ADDR_COUNT_LO);
   assign wr_cnt_hi = wr_en & (waddr_reg == ADDR_COUNT_HI);
   assign wr_count = wr_cnt_lo | wr_cnt_hi;
   assign wr_flags = wr_en & (waddr_reg == ADDR_IRQ_FLAGS);
   assign wr_enables = wr_en & (waddr_reg == ADDR_IRQ_ENABLES);
   assign wr_ctl = wr_en & (waddr_reg == ADDR_CONTROL);
   assign wr_pins = wr_en & (waddr_reg == ADDR_PIN_CTRL);

   // ----------------------------------------
   // Control and status
   // ----------------------------------------
   logic [5:0] ctl_reg;
   logic sysclk_from_timer_osc_reg;
   logic timer_run;
   logic clock_source_select;
   logic ext_clock_sync_n;
   logic timer_osc_enable;
   logic [1:0] prescale_select;

   assign timer_run = ctl_reg[CTL_RUN_BIT];
   assign clock_source_select = ctl_reg[CTL_CS_BIT];
   assign ext_clock_sync_n = ctl_reg[CTL_SYNC_N_BIT];
   assign timer_osc_enable = ctl_reg[CTL_OSCEN_BIT];
   assign prescale_select = ctl_reg[CTL_PS_LSB+1:CTL_PS_LSB];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_reg <= CTL_RESET;
      end else if (wr_ctl) begin
         ctl_reg <= wbyte_reg[5:0];
      end
   end

   // Status follows the clock switch; a failed oscillator drops it at the next aclk edge
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sysclk_from_timer_osc_reg <= 1'b0;
      end else begin
         sysclk_from_timer_osc_reg <= (system_clock_select == SYSCLK_SEL_TIMER_OSC) &&
                                      timer_osc_enable && !timer_osc_fail;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer_osc_inverter_en <= 1'b0;
      end else begin
         timer_osc_inverter_en <= timer_osc_enable;
      end
   end

   // ----------------------------------------
   // Tick sources
   // ----------------------------------------
   logic [7:0] div_reg;
   logic instr_tick_reg;
   logic ext_rise_sync;
   logic ext_rise_raw;
   tmc_mode_t mode;
   logic src_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         div_reg <= 8'h00;
         instr_tick_reg <= 1'b0;
      end else if (div_reg == 8'(INSTR_DIV - 1)) begin
         div_reg <= 8'h00;
         instr_tick_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 8'h01;
         instr_tick_reg <= 1'b0;
      end
   end

   // External count clock shares the oscillator amplifier pin
   tmc_edge_sync u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_i(osc_amp_output_pin_i),
      .rise_sync(ext_rise_sync),
      .rise_raw(ext_rise_raw)
   );

   always_comb begin
      if (!clock_source_select) begin
         mode = MODE_TIMER;
      end else if (ext_clock_sync_n) begin
         mode = MODE_ASYNC;
      end else begin
         mode = MODE_SYNC;
      end
   end

   // Unsynchronised mode still lives on aclk: it only saves the synchroniser delay
   always_comb begin
      unique case (mode)
         MODE_TIMER: src_tick = instr_tick_reg;
         MODE_SYNC: src_tick = ext_rise_sync;
         MODE_ASYNC: src_tick = ext_rise_raw;
         default: src_tick = 1'b0;
      endcase
   end

   // ----------------------------------------
   // Prescaler and count
   // ----------------------------------------
   tmc_pre_if pre_bus ();
   logic [15:0] count_reg;
   logic cnt_tick;
   logic ovf_event;

   assign pre_bus.tick_in = src_tick & timer_run;
   assign pre_bus.clear = wr_count;
   assign pre_bus.ratio_sel = prescale_select;

   tmc_prescaler #(
      .PRE_BITS(PRE_BITS)
   ) u_pre (
      .aclk(aclk),
      .aresetn(aresetn),
      .bus(pre_bus.pre)
   );

   assign cnt_tick = pre_bus.tick_out & timer_run;
   assign ovf_event = cnt_tick & (count_reg == COUNT_MAX) & ~wr_count & ~compare_unit_trigger;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_reg <= COUNT_ZERO;
      end else if (wr_count) begin
         if (wr_cnt_lo) begin
            count_reg[7:0] <= wbyte_reg;
         end
         if (wr_cnt_hi) begin
            count_reg[15:8] <= wbyte_reg;
         end
      end else if (compare_unit_trigger) begin
         count_reg <= COUNT_ZERO;
      end else if (cnt_tick) begin
         count_reg <= count_reg + 16'h0001;
      end
   end

   assign count_value = count_reg;

   // ----------------------------------------
   // Overflow flag and request
   // ----------------------------------------
   logic overflow_flag_reg;
   logic overflow_irq_enable_reg;

   // A wrap in the clearing cycle keeps the flag set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag_reg <= 1'b0;
      end else if (ovf_event) begin
         overflow_flag_reg <= 1'b1;
      end else if (wr_flags && wbyte_reg[OVF_BIT]) begin
         overflow_flag_reg <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq_enable_reg <= 1'b0;
      end else if (wr_enables) begin
         overflow_irq_enable_reg <= wbyte_reg[OVF_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_irq <= 1'b0;
      end else begin
         overflow_irq <= overflow_flag_reg & overflow_irq_enable_reg;
      end
   end

   // ----------------------------------------
   // Oscillator pins
   // ----------------------------------------
   logic [1:0] pin_out_reg;
   logic [1:0] pin_drv_reg;
   logic [1:0] pin_level;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out_reg <= 2'b00;
         pin_drv_reg <= 2'b00;
      end else if (wr_pins) begin
         pin_out_reg <= wbyte_reg[1:0];
         pin_drv_reg <= wbyte_reg[PIN_DRV_LSB+1:PIN_DRV_LSB];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         osc_amp_output_pin_oe <= 1'b0;
         osc_input_pin_oe <= 1'b0;
      end else begin
         osc_amp_output_pin_oe <= pin_drv_reg[0] & ~timer_osc_enable;
         osc_input_pin_oe <= pin_drv_reg[1] & ~timer_osc_enable;
      end
   end

   assign osc_amp_output_pin_o = pin_out_reg[0];
   assign osc_input_pin_o = pin_out_reg[1];
   assign pin_level = timer_osc_enable ? 2'b00 : {osc_input_pin_i, osc_amp_output_pin_i};

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   logic [7:0] rd_byte;
   logic rd_ok;

   always_comb begin
      rd_byte = 8'h00;
      rd_ok = 1'b1;
      unique case (s_axi_araddr)
         ADDR_COUNT_LO: rd_byte = count_reg[7:0];
         ADDR_COUNT_HI: rd_byte = count_reg[15:8];
         ADDR_IRQ_FLAGS: rd_byte = {7'h00, overflow_flag_reg};
         ADDR_IRQ_ENABLES: rd_byte = {7'h00, overflow_irq_enable_reg};
         ADDR_CONTROL: rd_byte = {1'b0, sysclk_from_timer_osc_reg, ctl_reg};
         ADDR_PIN_CTRL: rd_byte = {4'h0, pin_drv_reg, pin_out_reg};
         ADDR_PIN_READ: rd_byte = {6'h00, pin_level};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= RESP_OKAY;
         raddr_reg <= '0;
         arready_reg <= 1'b0;
      end else begin
         if (ar_hs) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, rd_byte};
            rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
            raddr_reg <= s_axi_araddr;
         end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
         end
         arready_reg <= ~ar_hs & ~(rvalid_reg & ~s_axi_rready);
      end
   end

   assign s_axi_awready = awready_reg;
   assign s_axi_wready = wready_reg;
   assign s_axi_bvalid = bvalid_reg;
   assign s_axi_bresp = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid = rvalid_reg;
   assign s_axi_rresp = rresp_reg;
   assign s_axi_rdata = rdata_reg;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   count_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
      cnt_tick && count_reg == COUNT_MAX && !wr_count && !compare_unit_trigger |=> count_reg == COUNT_ZERO)
      else $error("count did not wrap to zero");

   overflow_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ovf_event |=> overflow_flag_reg ##1 overflow_flag_reg || $past(wr_flags))
      else $error("overflow flag not latched");

   irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
      ((!overflow_irq_enable_reg) [*2] |-> !overflow_irq) and
      ((overflow_flag_reg && overflow_irq_enable_reg) [*2] |-> overflow_irq))
      else $error("request not gated by enable");

   run_freeze_a: assert property (@(posedge aclk) disable iff (!aresetn)
      !timer_run && !wr_count && !compare_unit_trigger |=> $stable(count_reg))
      else $error("count moved while stopped");

   trigger_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
      compare_unit_trigger && !wr_count && !overflow_flag_reg && !ovf_event
      |=> count_reg == COUNT_ZERO && !overflow_flag_reg)
      else $error("trigger did not clear count");

   write_wins_a: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_cnt_lo && compare_unit_trigger |=> count_reg[7:0] == $past(wbyte_reg))
      else $error("trigger beat software write");

   pin_input_a: assert property (@(posedge aclk) disable iff (!aresetn)
      timer_osc_enable [*2] |-> !osc_amp_output_pin_oe && !osc_input_pin_oe && pin_level == 2'b00)
      else $error("oscillator pins not forced to inputs");

   ctl_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
      rvalid_reg && raddr_reg == ADDR_CONTROL |-> rdata_reg[7] == 1'b0)
      else $error("control bit 7 read non-zero");

   status_bit_a: assert property (@(posedge aclk) disable iff (!aresetn)
      system_clock_select != SYSCLK_SEL_TIMER_OSC |=> !sysclk_from_timer_osc_reg)
      else $error("status set without timer clock select");

endmodule // tmc_timer_top

// ===== tb/tmc_ext_clk.sv
/* External count clock source for the timer's count pin.
   Assumes aclk; the pin stands low between bursts. */
`timescale 1ns/1ps
module tmc_ext_clk (
   input wire logic aclk,
   input wire logic start,
   input wire logic [3:0] n,
   output logic pin,
   output logic busy
);
   logic [6:0] cnt_reg = 7'h00;
   // Eight aclk per period so both edge paths can see every edge
   always @(posedge aclk) begin
      if (start) begin
         cnt_reg <= {n, 3'b000};
      end else if (busy) begin
         cnt_reg <= cnt_reg - 7'h01;
      end
   end
   assign busy = cnt_reg != 7'h00;
   assign pin = cnt_reg[2] & busy;
endmodule // tmc_ext_clk

// ===== tb/sixteen_bit_timer_counter_test.sv
/* Self-checking bench of the 16-bit timer/counter over its register bus.
   Assumes tmc_pkg, tmc_timer_top and tmc_ext_clk are compiled first. */
`timescale 1ns/1ps
module sixteen_bit_timer_counter_test;
   import tmc_pkg::*;
   logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1, compare_unit_trigger = 1'b0, timer_osc_fail = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, v;
   logic [3:0] s_axi_wstrb = 4'h1;
   logic [1:0] system_clock_select = 2'h0, s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflow_irq, xs = 1'b0, xp, xb;
   logic osc_amp_output_pin_o, osc_amp_output_pin_oe, osc_input_pin_o, osc_input_pin_oe, timer_osc_inverter_en;
   logic [15:0] count_value;
   wire osc_amp_output_pin_i = osc_amp_output_pin_oe ? osc_amp_output_pin_o : xp;
   wire osc_input_pin_i = osc_input_pin_oe ? osc_input_pin_o : 1'b1;
   int fail_count = 0, cmp_count = 0, k;

   always #12.5 aclk = ~aclk;
   tmc_timer_top #(.INSTR_DIV(2)) i_dut (.*);
   tmc_ext_clk i_ext (.aclk(aclk), .start(xs), .n(4'h7), .pin(xp), .busy(xb));

   // ----------------------------------------
   // Bus and compare tasks
   // ----------------------------------------
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s: expected %h, seen %h", s, e, g);
      end
   endtask
   // Waits as long as the slave takes; only the watchdog ends a hang
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      chk("bresp", RESP_OKAY, s_axi_bresp);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      rs = s_axi_rresp;
   endtask
   task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
      rd(a, v, r);
      chk(s, e, v);
   endtask
   task automatic edges();
      int i;
      xs <= 1'b1;
      @(posedge aclk);
      xs <= 1'b0;
      repeat (2) @(posedge aclk);
      for (i = 0; i < 200 && xb; i++) @(posedge aclk);
      repeat (8) @(posedge aclk);
   endtask
   task automatic results();
      $display("compares %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      rc("control", ADDR_CONTROL, 32'h0000_0000);
      rd(8'h40, v, r);
      chk("rresp", RESP_SLVERR, r);
      wr(ADDR_COUNT_LO, 8'hA5);
      wr(ADDR_COUNT_HI, 8'h5A);
      rc("count_lo", ADDR_COUNT_LO, 32'h0000_00A5);
      rc("count_hi", ADDR_COUNT_HI, 32'h0000_005A);
      $display("test registers done");
      wr(ADDR_COUNT_LO, 8'hFE);
      wr(ADDR_COUNT_HI, 8'hFF);
      wr(ADDR_IRQ_ENABLES, 8'h01);
      wr(ADDR_CONTROL, 8'h01);
      for (k = 0; k < 200 && overflow_irq !== 1'b1; k++) @(posedge aclk);
      wr(ADDR_CONTROL, 8'h00);
      chk("irq", 1, overflow_irq);
      chk("wrapped", 1, count_value < 16'h0010);
      rc("flag", ADDR_IRQ_FLAGS, 32'h0000_0001);
      wr(ADDR_IRQ_ENABLES, 8'h00);
      repeat (2) @(posedge aclk);
      chk("irq masked", 0, overflow_irq);
      wr(ADDR_IRQ_FLAGS, 8'h01);
      rc("flag", ADDR_IRQ_FLAGS, 32'h0000_0000);
      $display("test overflow done");
      // Same ratio twice in a row: a stale prescaler would add one step
      for (k = 0; k < 8; k++) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_COUNT_LO, 8'h00);
         wr(ADDR_COUNT_HI, 8'h00);
         wr(ADDR_CONTROL, {2'b00, k[2:1], 1'b0, k[0], 2'b11});
         edges();
         chk("ext count", 32'h7 >> k[2:1], count_value);
      end
      $display("test prescale done");
      wr(ADDR_CONTROL, 8'h02);
      wr(ADDR_COUNT_LO, 8'h34);
      edges();
      chk("frozen", 32'h34, count_value);
      compare_unit_trigger <= 1'b1;
      @(posedge aclk);
      compare_unit_trigger <= 1'b0;
      repeat (2) @(posedge aclk);
      chk("trigger", 0, count_value);
      // Trigger lands in the commit cycle of the count write
      fork
         wr(ADDR_COUNT_LO, 8'h77);
         begin
            @(posedge aclk);
            compare_unit_trigger <= 1'b1;
            @(posedge aclk);
            compare_unit_trigger <= 1'b0;
         end
      join
      rc("write wins", ADDR_COUNT_LO, 32'h0000_0077);
      s_axi_wstrb <= 4'h0;
      wr(ADDR_COUNT_LO, 8'h11);
      s_axi_wstrb <= 4'h1;
      rc("no strobe", ADDR_COUNT_LO, 32'h0000_0077);
      $display("test freeze and trigger done");
      system_clock_select <= SYSCLK_SEL_TIMER_OSC;
      wr(ADDR_PIN_CTRL, 8'h0F);
      repeat (2) @(posedge aclk);
      chk("pin drive", 1, osc_amp_output_pin_oe);
      chk("pin out", 32'h0000_0007, {osc_input_pin_oe, osc_input_pin_o, osc_amp_output_pin_o});
      wr(ADDR_CONTROL, 8'h08);
      repeat (2) @(posedge aclk);
      chk("pin oe", 0, {osc_amp_output_pin_oe, osc_input_pin_oe});
      chk("osc on", 1, timer_osc_inverter_en);
      rc("pin read", ADDR_PIN_READ, 32'h0000_0000);
      rc("status", ADDR_CONTROL, 32'h0000_0048);
      timer_osc_fail <= 1'b1;
      repeat (2) @(posedge aclk);
      rc("status", ADDR_CONTROL, 32'h0000_0008);
      wr(ADDR_CONTROL, 8'h00);
      repeat (2) @(posedge aclk);
      chk("osc off", 0, timer_osc_inverter_en);
      $display("test oscillator done");
      results();
   end

   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge aclk);
      fail_count++;
      results();
   end
endmodule // sixteen_bit_timer_counter_test
